// ### rtl/baud_sel_pkg.sv
// package: register map, select codes and divisor table for the bit-rate clock selector
package baud_sel_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] RX_CLOCK_SOURCE_ADDR = 8'h30;
    localparam logic [7:0] TX_CLOCK_SOURCE_ADDR = 8'h31;
    localparam int         SEL_W                = 6;
    localparam int         DIV_W                = 15;
    localparam logic [5:0] SEL_RESET            = 6'h0B;

    // ----------------------------------------------------------------
    // fixed-table bounds and the select codes outside the fixed table
    // ----------------------------------------------------------------
    localparam logic [5:0] CODE_FIXED_LO_MAX = 6'h0C;
    localparam logic [5:0] CODE_TIMER0       = 6'h0D;
    localparam logic [5:0] CODE_EXT_X16      = 6'h0E;
    localparam logic [5:0] CODE_EXT_X1       = 6'h0F;
    localparam logic [5:0] CODE_FIXED_HI_MIN = 6'h10;
    localparam logic [5:0] CODE_FIXED_HI_MAX = 6'h1C;
    localparam logic [5:0] CODE_TIMER1       = 6'h1D;
    localparam logic [5:0] CODE_PRG0         = 6'h1E;
    localparam logic [5:0] CODE_MIDI         = 6'h1F;
    localparam logic [5:0] CODE_PRG1         = 6'h3E;

    // ----------------------------------------------------------------
    // crystal-relative divisors for a 16x tick: crystal / (16 * rate)
    // ----------------------------------------------------------------
    localparam logic [DIV_W-1:0] DIV_LO [0:12] = '{
        15'h4800, 15'h20BA, 15'h1AC4, 15'h1200, 15'h0C00, 15'h0600, 15'h0300,
        15'h036E, 15'h0180, 15'h00C0, 15'h0080, 15'h0060, 15'h0018};
    localparam logic [DIV_W-1:0] DIV_HI [0:12] = '{
        15'h3000, 15'h1800, 15'h0800, 15'h0200, 15'h01CD, 15'h0040, 15'h0030,
        15'h0020, 15'h0010, 15'h0008, 15'h0004, 15'h0002, 15'h0001};
    localparam logic [DIV_W-1:0] DIV_MIDI = 15'h001D;

    // ----------------------------------------------------------------
    // per-channel clock output
    // ----------------------------------------------------------------
    typedef struct packed {
        logic tick;
        logic x1;
        logic active;
    } chan_clk_s;

endpackage : baud_sel_pkg

// ### rtl/uart_baud_clock_select.sv
// module: receiver and transmitter bit-rate clock source selection
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

module uart_baud_clock_select
(
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_resetn,
    input  wire logic                     i_crystal_en,
    input  wire logic [7:0]               i_addr,
    input  wire logic [7:0]               i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic      [7:0]               o_rdata,
    input  wire logic                     i_tx_ext_clk,
    input  wire logic                     i_rx_ext_clk,
    input  wire logic                     i_timer0_tick,
    input  wire logic                     i_timer1_tick,
    input  wire logic                     i_prg0_tick,
    input  wire logic                     i_prg1_tick,
    output baud_sel_pkg::chan_clk_s       o_rx_clk,
    output baud_sel_pkg::chan_clk_s       o_tx_clk
);

    // ----------------------------------------------------------------
    // select registers (index 0 = receiver, 1 = transmitter)
    // ----------------------------------------------------------------
    logic [baud_sel_pkg::SEL_W-1:0] sel_r [0:1];
    logic [7:0]                     rdata_r;
    logic                           ext_prev_r [0:1];
    logic [baud_sel_pkg::DIV_W-1:0] cnt_r [0:1];
    baud_sel_pkg::chan_clk_s        clk_r [0:1];
    logic                           ext_pin [0:1];

    assign ext_pin[0] = i_rx_ext_clk;
    assign ext_pin[1] = i_tx_ext_clk;

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sel_r[0] <= baud_sel_pkg::SEL_RESET;
            sel_r[1] <= baud_sel_pkg::SEL_RESET;
        end
        else if (i_wr)
        begin
            if (i_addr == baud_sel_pkg::RX_CLOCK_SOURCE_ADDR)
                sel_r[0] <= i_wdata[baud_sel_pkg::SEL_W-1:0];
            if (i_addr == baud_sel_pkg::TX_CLOCK_SOURCE_ADDR)
                sel_r[1] <= i_wdata[baud_sel_pkg::SEL_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // read port: data valid in the cycle after the strobe only
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rdata_r <= 8'h00;
        else if (i_rd && i_addr == baud_sel_pkg::RX_CLOCK_SOURCE_ADDR)
            rdata_r <= {2'b00, sel_r[0]};
        else if (i_rd && i_addr == baud_sel_pkg::TX_CLOCK_SOURCE_ADDR)
            rdata_r <= {2'b00, sel_r[1]};
        else
            rdata_r <= 8'h00;
    end

    assign o_rdata = rdata_r;

    // ----------------------------------------------------------------
    // divisor lookup; zero means no crystal-derived rate for the code
    // ----------------------------------------------------------------
    function automatic logic [baud_sel_pkg::DIV_W-1:0] div_of(input logic [5:0] code);
        logic [baud_sel_pkg::DIV_W-1:0] d;
        d = '0;
        if (code <= baud_sel_pkg::CODE_FIXED_LO_MAX)
            d = baud_sel_pkg::DIV_LO[code[3:0]];
        else if (code >= baud_sel_pkg::CODE_FIXED_HI_MIN && code <= baud_sel_pkg::CODE_FIXED_HI_MAX)
            d = baud_sel_pkg::DIV_HI[code[3:0]];
        else if (code == baud_sel_pkg::CODE_MIDI)
            d = baud_sel_pkg::DIV_MIDI;
        return d;
    endfunction : div_of

    // ----------------------------------------------------------------
    // per-channel generator and source multiplexer
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            logic [baud_sel_pkg::DIV_W-1:0] div;
            logic                           gen_tick;
            logic                           ext_rise;
            baud_sel_pkg::chan_clk_s        clk_nxt;

            assign div      = div_of(sel_r[ch]);
            assign ext_rise = ext_pin[ch] && !ext_prev_r[ch];
            // counts crystal enables, so rates track the crystal frequency
            assign gen_tick = i_crystal_en && (div != '0) && (cnt_r[ch] == '0);

            always_ff @(posedge i_sys_clk or negedge i_resetn)
            begin
                if (!i_resetn)
                    cnt_r[ch] <= '0;
                else if (div == '0)
                    cnt_r[ch] <= '0;
                else if (i_crystal_en)
                begin
                    // reload on terminal count or when the code shrinks the period
                    if (cnt_r[ch] == '0 || cnt_r[ch] >= div)
                        cnt_r[ch] <= div - 15'h0001;
                    else
                        cnt_r[ch] <= cnt_r[ch] - 15'h0001;
                end
            end

            always_ff @(posedge i_sys_clk or negedge i_resetn)
            begin
                if (!i_resetn)
                    ext_prev_r[ch] <= 1'b0;
                else
                    ext_prev_r[ch] <= ext_pin[ch];
            end

            always_comb
            begin
                clk_nxt = '{tick: 1'b0, x1: 1'b0, active: 1'b1};
                case (sel_r[ch])
                    baud_sel_pkg::CODE_TIMER0: clk_nxt.tick = i_timer0_tick;
                    baud_sel_pkg::CODE_TIMER1: clk_nxt.tick = i_timer1_tick;
                    baud_sel_pkg::CODE_PRG0:   clk_nxt.tick = i_prg0_tick;
                    baud_sel_pkg::CODE_PRG1:   clk_nxt.tick = i_prg1_tick;
                    baud_sel_pkg::CODE_EXT_X16: clk_nxt.tick = ext_rise;
                    baud_sel_pkg::CODE_EXT_X1:
                    begin
                        clk_nxt.tick = ext_rise;
                        clk_nxt.x1   = 1'b1;
                    end
                    default:
                    begin
                        // reserved codes have no divisor: channel stays idle
                        clk_nxt.tick   = gen_tick;
                        clk_nxt.active = (div != '0);
                    end
                endcase
            end

            always_ff @(posedge i_sys_clk or negedge i_resetn)
            begin
                if (!i_resetn)
                    clk_r[ch] <= '0;
                else
                    clk_r[ch] <= clk_nxt;
            end
        end
    endgenerate

    assign o_rx_clk = clk_r[0];
    assign o_tx_clk = clk_r[1];

endmodule : uart_baud_clock_select

// ### test/uart_baud_clock_select_assertions.sv
// checker: port-level properties of the bit-rate clock selector
`timescale 1ns/1ps
module uart_baud_clock_select_checker
(
    input wire logic                    i_sys_clk,
    input wire logic                    i_resetn,
    input wire logic                    i_crystal_en,
    input wire logic [7:0]              i_addr,
    input wire logic [7:0]              i_wdata,
    input wire logic                    i_wr,
    input wire logic                    i_rd,
    input wire logic [7:0]              o_rdata,
    input wire logic                    i_tx_ext_clk,
    input wire logic                    i_rx_ext_clk,
    input wire logic                    i_timer0_tick,
    input wire logic                    i_timer1_tick,
    input wire logic                    i_prg0_tick,
    input wire logic                    i_prg1_tick,
    input wire baud_sel_pkg::chan_clk_s o_rx_clk,
    input wire baud_sel_pkg::chan_clk_s o_tx_clk
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    property p_rd_top; $past(i_rd) |-> o_rdata[7:6] == 2'h0; endproperty
    a_rd_top: assert property (p_rd_top) else $error("reserved read bits not zero");
    property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_readback; i_wr && i_addr == 8'h30 ##1 i_rd && i_addr == 8'h30
        |=> o_rdata == {2'h0, $past(i_wdata[5:0], 2)}; endproperty
    a_readback: assert property (p_readback) else $error("receiver select readback wrong");
    property p_tx_x1; i_wr && i_addr == 8'h31 && i_wdata[5:0] == 6'h0F |=> ##1 o_tx_clk.x1 && o_tx_clk.active;
    endproperty
    a_tx_x1: assert property (p_tx_x1) else $error("tx 1x mode not shown");
    property p_tx_idle; i_wr && i_addr == 8'h31 && i_wdata[5:4] == 2'h3 && i_wdata[5:0] != 6'h3E
        |=> ##1 !o_tx_clk.active && !o_tx_clk.tick; endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("reserved code left tx active");
    property p_rx_ext; o_rx_clk.x1 && $rose(i_rx_ext_clk) ##1 o_rx_clk.x1 |-> o_rx_clk.tick; endproperty
    a_rx_ext: assert property (p_rx_ext) else $error("rx pin edge gave no tick");
    property p_tx_ext; o_tx_clk.x1 && $rose(i_tx_ext_clk) ##1 o_tx_clk.x1 |-> o_tx_clk.tick; endproperty
    a_tx_ext: assert property (p_tx_ext) else $error("tx pin edge gave no tick");
    property p_tx_one; o_tx_clk.tick && o_tx_clk.x1 |=> !o_tx_clk.tick; endproperty
    a_tx_one: assert property (p_tx_one) else $error("tx 1x tick longer than one cycle");
endmodule : uart_baud_clock_select_checker
bind uart_baud_clock_select uart_baud_clock_select_checker i_chk (.i_sys_clk, .i_resetn, .i_crystal_en,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tx_ext_clk, .i_rx_ext_clk, .i_timer0_tick,
    .i_timer1_tick, .i_prg0_tick, .i_prg1_tick, .o_rx_clk, .o_tx_clk);

// ### test/uart_baud_clock_select_tb_top.sv
// testbench: register access and clock-source selection of the bit-rate selector
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module uart_baud_clock_select_tb_top;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, xt = 1, rxp = 0, txp = 0, half = 0, rd_d = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, exp_v, d, rx_n, tx_n;
    logic [3:0] src = 4'h0;
    logic [7:0] expq[$];
    baud_sel_pkg::chan_clk_s receive_clock_input, txc;
    int num_errors = 0, comparisons = 0, cyc = 0;
    uart_baud_clock_select i_dut (.i_sys_clk(clk), .i_resetn(rst_n), .i_crystal_en(xt), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_ext_clk(txp), .i_rx_ext_clk(rxp),
        .i_timer0_tick(src[0]), .i_timer1_tick(src[1]), .i_prg0_tick(src[2]), .i_prg1_tick(src[3]),
        .o_rx_clk(receive_clock_input), .o_tx_clk(txc));
    // 10 MHz stands in for the crystal, well inside the supported ceiling
    initial forever #50 clk = ~clk;
    // periods 1, 2, 4 and 29 all divide the 116-cycle count window, so counts are phase-free
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        src <= {cyc % 29 == 0, cyc % 4 == 0, cyc % 2 == 0, 1'b1};
        rxp <= cyc % 4 >= 2;
        txp <= cyc % 2 == 1;
        xt <= half ? cyc % 2 == 0 : 1'b1;
        if (rd_d)
        begin
            exp_v = expq.pop_front();
            `CHK("read data", exp_v, rdata)
        end
        rd_d <= rd;
        if (cyc > 5000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= v;
        if (!w) expq.push_back(v);
    endtask : bus
    task automatic row(input logic [5:0] c, input logic [7:0] erx, input logic [7:0] etx);
        bus(1, 8'h30, {2'h0, c});
        bus(1, 8'h31, {2'h0, c});
        bus(0, 8'h31, {2'h0, c});
        @(posedge clk);
        rd <= 0;
        repeat (8) @(posedge clk);
        rx_n = 8'h00;
        tx_n = 8'h00;
        repeat (116)
        begin
            @(posedge clk);
            rx_n += receive_clock_input.tick;
            tx_n += txc.tick;
        end
        `CHK("rx ticks", erx, rx_n)
        `CHK("tx ticks", etx, tx_n)
        `CHK("tx x1", c == 6'h0F, txc.x1)
        `CHK("rx x1", c == 6'h0F, receive_clock_input.x1)
        `CHK("tx active", c[5:4] != 2'h3 || c == 6'h3E, txc.active)
        `CHK("rx active", c[5:4] != 2'h3 || c == 6'h3E, receive_clock_input.active)
        $display("test code %h done", c);
    endtask : row
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    initial
    begin
        void'($urandom(80510));
        repeat (16) @(posedge clk);
        rst_n <= 1;
        bus(0, 8'h30, {2'h0, baud_sel_pkg::SEL_RESET});
        bus(0, 8'h31, {2'h0, baud_sel_pkg::SEL_RESET});
        repeat (6)
        begin
            d = 8'($urandom);
            bus(1, 8'h31, ~d);
            bus(1, 8'h32, 8'h3F);
            bus(1, 8'h30, d);
            bus(0, 8'h30, {2'h0, d[5:0]});
            bus(0, 8'h31, {2'h0, ~d[5:0]});
            bus(0, 8'h32, 8'h00);
        end
        $display("test register access done");
        row(6'h1C, 8'd116, 8'd116);
        row(6'h1B, 8'd58, 8'd58);
        row(6'h1A, 8'd29, 8'd29);
        row(6'h1F, 8'd4, 8'd4);
        row(6'h0D, 8'd116, 8'd116);
        row(6'h1D, 8'd58, 8'd58);
        row(6'h1E, 8'd29, 8'd29);
        row(6'h3E, 8'd4, 8'd4);
        row(6'h0E, 8'd29, 8'd58);
        row(6'h0F, 8'd29, 8'd58);
        row(6'h30, 8'd0, 8'd0);
        row(6'h3F, 8'd0, 8'd0);
        half <= 1;
        row(6'h1C, 8'd58, 8'd58);
        // mid-run reset must bring both selects back to their reset code
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        bus(0, 8'h30, {2'h0, baud_sel_pkg::SEL_RESET});
        bus(0, 8'h31, {2'h0, baud_sel_pkg::SEL_RESET});
        @(posedge clk);
        rd <= 0;
        repeat (3) @(posedge clk);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule : uart_baud_clock_select_tb_top
